// >>> dadc_top.sv
// Control logic of a two-channel simultaneous-sampling converter with serial port

module dadc_top #(
   parameter int unsigned DATA_W = dadc_pkg::DATA_BITS   // Result width per channel
)
(
   input  wire logic              mclk,                  // System clock, 25 MHz
   input  wire logic              srst,                  // Synchronous reset, active high
   input  wire logic              sck_pin,               // Host shift clock pin
   input  wire logic              convert_strobe,        // Host convert strobe pin
   input  wire logic [DATA_W-1:0] channel_zero_positive, // Channel 0 result from converter core
   input  wire logic [DATA_W-1:0] channel_one_positive,  // Channel 1 result from converter core
   output logic                   serial_result_out,     // Serial data, output value
   output logic                   serial_result_oe,      // Serial data, output enable
   output logic                   convert_strobe_busy,             // Conversion in progress
   output logic                   acquiring,             // Acquisition interval
   output logic                   nap_active,            // Nap state
   output logic                   sleep_active,          // Sleep state
   output logic                   reference_on           // Internal reference powered
);

   localparam int unsigned PAD_W = dadc_pkg::WORD_BITS - DATA_W;

   logic                          sck_rise;
   logic                          convert_strobe_rise;
   logic [DATA_W-1:0]             held0_q;
   logic [DATA_W-1:0]             held1_q;
   logic [dadc_pkg::FRAME_BITS-1:0] shift_q;
   logic [5:0]                    bit_cnt_q;
   logic [2:0]                    pulse_cnt_q;
   dadc_pkg::dadc_pwr_state_t     state_q;
   dadc_pkg::dadc_pwr_state_t     state_d;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   dadc_edge_sync u_sck_sync
   (
      .mclk     (mclk),
      .srst     (srst),
      .async_in (sck_pin),
      .level    (),
      .rise     (sck_rise)
   );

   dadc_edge_sync u_convert_strobe_sync
   (
      .mclk     (mclk),
      .srst     (srst),
      .async_in (convert_strobe),
      .level    (),
      .rise     (convert_strobe_rise)
   );

   // ----------------------------------------------------------------
   // Sample hold
   // ----------------------------------------------------------------
   // Both channels load on the same edge so they share one sample time
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         held0_q <= '0;
         held1_q <= '0;
      end
      else if (convert_strobe_rise)
      begin
         held0_q <= channel_zero_positive;
         held1_q <= channel_one_positive;
      end
   end

   // ----------------------------------------------------------------
   // Result shifter and frame counter
   // ----------------------------------------------------------------
   // The shifter loads the samples held before this strobe, so output lags one conversion
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         shift_q           <= '0;
         bit_cnt_q         <= dadc_pkg::BIT_CNT_RST;
         serial_result_oe  <= 1'b0;
         serial_result_out <= 1'b0;
      end
      else if (convert_strobe_rise)
      begin
         shift_q           <= {{PAD_W{1'b0}}, held0_q, {PAD_W{1'b0}}, held1_q};
         bit_cnt_q         <= dadc_pkg::BIT_CNT_RST;
         serial_result_oe  <= 1'b1;
         serial_result_out <= 1'b0;                                             // Leading pad bit
      end
      else if (sck_rise && serial_result_oe)
      begin
         bit_cnt_q <= bit_cnt_q + 6'h01;
         if (bit_cnt_q == dadc_pkg::LAST_BIT_IDX)
         begin
            serial_result_oe  <= 1'b0;
            serial_result_out <= 1'b0;
         end
         else
         begin
            shift_q           <= shift_q << 1;
            serial_result_out <= shift_q[dadc_pkg::FRAME_BITS-2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Conversion and acquisition phases
   // ----------------------------------------------------------------
   // Acquisition opens at the 32nd shift clock rise and closes at the next strobe
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         convert_strobe_busy <= 1'b0;
         acquiring <= 1'b1;
      end
      else if (convert_strobe_rise)
      begin
         convert_strobe_busy <= 1'b1;
         acquiring <= 1'b0;
      end
      else if (sck_rise && convert_strobe_busy && bit_cnt_q == dadc_pkg::LAST_BIT_IDX)
      begin
         convert_strobe_busy <= 1'b0;
         acquiring <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Strobe counter for power-down requests
   // ----------------------------------------------------------------
   // A strobe in the same cycle as a clock edge counts as the first of a new run
   always_ff @(posedge mclk)
   begin
      if (srst)
         pulse_cnt_q <= dadc_pkg::PULSE_CNT_RST;
      else if (sck_rise)
         pulse_cnt_q <= convert_strobe_rise ? 3'h1 : dadc_pkg::PULSE_CNT_RST;
      else if (convert_strobe_rise && pulse_cnt_q < dadc_pkg::SLEEP_PULSES)
         pulse_cnt_q <= pulse_cnt_q + 3'h1;
   end

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   // Wake holds the reference off until a nap request follows the sleep exit
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         dadc_pkg::PWR_ACTIVE:
         begin
            if (!sck_rise && pulse_cnt_q >= dadc_pkg::SLEEP_PULSES)
               state_d = dadc_pkg::PWR_SLEEP;
            else if (!sck_rise && pulse_cnt_q >= dadc_pkg::NAP_PULSES)
               state_d = dadc_pkg::PWR_NAP;
         end
         dadc_pkg::PWR_NAP:
         begin
            if (sck_rise)
               state_d = dadc_pkg::PWR_ACTIVE;
            else if (pulse_cnt_q >= dadc_pkg::SLEEP_PULSES)
               state_d = dadc_pkg::PWR_SLEEP;
         end
         dadc_pkg::PWR_SLEEP:
         begin
            if (sck_rise)
               state_d = dadc_pkg::PWR_WAKE;
         end
         dadc_pkg::PWR_WAKE:
         begin
            if (!sck_rise && pulse_cnt_q >= dadc_pkg::NAP_PULSES)
               state_d = dadc_pkg::PWR_NAP;
         end
      endcase
   end

   // State and decoded outputs share one edge
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state_q      <= dadc_pkg::PWR_ACTIVE;
         nap_active   <= 1'b0;
         sleep_active <= 1'b0;
         reference_on <= 1'b1;
      end
      else
      begin
         state_q      <= state_d;
         nap_active   <= (state_d == dadc_pkg::PWR_NAP);
         sleep_active <= (state_d == dadc_pkg::PWR_SLEEP);
         reference_on <= (state_d == dadc_pkg::PWR_ACTIVE) || (state_d == dadc_pkg::PWR_NAP);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_strobe_starts;
      @(posedge mclk) disable iff (srst)
      convert_strobe_rise |=> convert_strobe_busy && serial_result_oe && !acquiring;
   endproperty
   a_strobe_starts: assert property (p_strobe_starts)
      else $error("strobe did not start a conversion");

   property p_common_sample;
      @(posedge mclk) disable iff (srst)
      convert_strobe_rise |=> held0_q == $past(channel_zero_positive) && held1_q == $past(channel_one_positive);
   endproperty
   a_common_sample: assert property (p_common_sample)
      else $error("channels not captured together");

   property p_bit_step;
      @(posedge mclk) disable iff (srst)
      sck_rise && serial_result_oe && !convert_strobe_rise && bit_cnt_q != dadc_pkg::LAST_BIT_IDX
         |=> bit_cnt_q == $past(bit_cnt_q) + 6'h01 && serial_result_out == $past(shift_q[30]);
   endproperty
   a_bit_step: assert property (p_bit_step)
      else $error("shift clock rise did not advance data");

   property p_release;
      @(posedge mclk) disable iff (srst)
      !serial_result_oe |-> !serial_result_out;
   endproperty
   a_release: assert property (p_release)
      else $error("data driven while released");

   property p_latency;
      @(posedge mclk) disable iff (srst)
      convert_strobe_rise |=> shift_q[29:16] == $past(held0_q) && shift_q[13:0] == $past(held1_q);
   endproperty
   a_latency: assert property (p_latency)
      else $error("frame does not hold previous samples");

   property p_nap;
      @(posedge mclk) disable iff (srst)
      state_q == dadc_pkg::PWR_ACTIVE && !sck_rise && pulse_cnt_q == dadc_pkg::NAP_PULSES |=> nap_active;
   endproperty
   a_nap: assert property (p_nap)
      else $error("nap not entered after two strobes");

   property p_sleep;
      @(posedge mclk) disable iff (srst)
      state_q != dadc_pkg::PWR_WAKE && !sck_rise && pulse_cnt_q == dadc_pkg::SLEEP_PULSES
         |=> sleep_active && !reference_on;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep not entered after four strobes");

   property p_wake;
      @(posedge mclk) disable iff (srst)
      state_q == dadc_pkg::PWR_SLEEP && sck_rise |=> !sleep_active ##1 !sleep_active;
   endproperty
   a_wake: assert property (p_wake)
      else $error("clock pulse did not leave sleep");

   property p_ref_nap;
      @(posedge mclk) disable iff (srst)
      nap_active |-> reference_on;
   endproperty
   a_ref_nap: assert property (p_ref_nap)
      else $error("reference off during nap");

   property p_reset_active;
      @(posedge mclk)
      $past(srst) && !srst |-> !nap_active && !sleep_active && reference_on && acquiring;
   endproperty
   a_reset_active: assert property (p_reset_active)
      else $error("not active after reset");

   property p_acq_open;
      @(posedge mclk) disable iff (srst)
      sck_rise && convert_strobe_busy && !convert_strobe_rise && bit_cnt_q == dadc_pkg::LAST_BIT_IDX |=> acquiring && !serial_result_oe;
   endproperty
   a_acq_open: assert property (p_acq_open)
      else $error("acquisition did not open at 32nd rise");

   property p_count;
      @(posedge mclk) disable iff (srst)
      (sck_rise && !convert_strobe_rise |=> pulse_cnt_q == 3'h0) and
      (!sck_rise && pulse_cnt_q == dadc_pkg::SLEEP_PULSES |=> pulse_cnt_q == dadc_pkg::SLEEP_PULSES);
   endproperty
   a_count: assert property (p_count)
      else $error("strobe counter wrong");

   c_nap:   cover property (@(posedge mclk) disable iff (srst) $rose(nap_active));
   c_sleep: cover property (@(posedge mclk) disable iff (srst) $rose(sleep_active));
   c_frame: cover property (@(posedge mclk) disable iff (srst) $fell(serial_result_oe) ##[1:1000] convert_strobe_rise);
   c_back:  cover property (@(posedge mclk) disable iff (srst)
      state_q == dadc_pkg::PWR_WAKE ##[1:1000] state_q == dadc_pkg::PWR_ACTIVE);

endmodule

// >>> dadc_pkg.sv
// Shared constants and types for the dual-channel converter control block
package dadc_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int unsigned FRAME_BITS   = 32;        // Two result words per frame
   localparam int unsigned WORD_BITS    = 16;        // One word per channel
   localparam int unsigned DATA_BITS    = 14;        // Result bits inside a word
   localparam logic [5:0]  BIT_CNT_RST  = 6'h00;     // Bit counter after reset
   localparam logic [5:0]  LAST_BIT_IDX = 6'h1F;     // Index at the 32nd shift clock rise

   // ----------------------------------------------------------------
   // Power control
   // ----------------------------------------------------------------
   localparam logic [2:0]  PULSE_CNT_RST = 3'h0;     // Strobe counter after reset
   localparam logic [2:0]  NAP_PULSES    = 3'h2;     // Strobes with no clock edge for nap
   localparam logic [2:0]  SLEEP_PULSES  = 3'h4;     // Strobes with no clock edge for sleep

   typedef enum logic [1:0]
   {
      PWR_ACTIVE = 2'b00,
      PWR_NAP    = 2'b01,
      PWR_SLEEP  = 2'b10,
      PWR_WAKE   = 2'b11
   } dadc_pwr_state_t;

endpackage

// >>> dadc_edge_sync.sv
// Two-flop synchroniser with rising edge detection for one pin
module dadc_edge_sync
(
   input  wire logic mclk,       // System clock
   input  wire logic srst,       // Synchronous reset, active high
   input  wire logic async_in,   // Pin from outside the clock domain
   output logic      level,      // Synchronised level
   output logic      rise        // One-cycle pulse on a rising edge
);

   logic meta_q;
   logic sync_q;
   logic prev_q;

   // ----------------------------------------------------------------
   // Synchroniser chain; meta_q feeds only sync_q
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge taken only from settled flops
   assign level = sync_q;
   assign rise  = sync_q & ~prev_q;

endmodule

// >>> dadc_host_model.sv
// Host serial controller model: drives strobe and shift clock, collects frames
module dadc_host_model
(
   input  wire logic        mclk,            // System clock
   input  wire logic        sdo_out,         // Data value from device
   input  wire logic        sdo_oe,          // Data enable from device
   output logic             sck_pin,         // Shift clock to device
   output logic             convert_strobe,  // Convert strobe to device
   output logic             frame_done,      // Pulse after the 32nd bit
   output logic [31:0]      frame_word,      // Bits taken, first bit in MSB
   output logic             oe_gap           // Line seen released in a frame
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       wire_last_q = 1'b0;  // Last level seen on the line
   logic       sdo_wire;            // Level on the line
   int         bit_cnt = 0;         // Bits taken since the strobe

   // --------------------------------------------------------------
   // Line and pin levels
   // --------------------------------------------------------------
   // A released line toggles, so a stale bit cannot pass as data
   assign sdo_wire = sdo_oe ? sdo_out : ~wire_last_q;
   always_ff @(posedge mclk) wire_last_q <= sdo_wire;
   initial
   begin
      sck_pin        = 1'b0;
      convert_strobe = 1'b0;
      frame_done     = 1'b0;
      frame_word     = '0;
      oe_gap         = 1'b0;
   end

   // --------------------------------------------------------------
   // Host operations
   // --------------------------------------------------------------
   // Strobe high 4 and low 8 cycles; the gap also covers the synchroniser delay
   task automatic strobe_pulse();
      @(posedge mclk);
      convert_strobe <= 1'b1;
      bit_cnt = 0;
      oe_gap  = 1'b0;
      repeat (4) @(posedge mclk);
      convert_strobe <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask

   // Clock stands low outside pulses; a bit is taken at each rise
   task automatic sck_pulses(input int n);
      repeat (n)
      begin
         @(posedge mclk);
         sck_pin <= 1'b1;
         frame_word = {frame_word[30:0], sdo_wire};
         if (sdo_oe !== 1'b1) oe_gap = 1'b1;
         bit_cnt++;
         repeat (4) @(posedge mclk);
         sck_pin <= 1'b0;
         repeat (3) @(posedge mclk);
         if (bit_cnt == 32)
         begin
            frame_done <= 1'b1;
            @(posedge mclk);
            frame_done <= 1'b0;
         end
      end
   endtask
endmodule

// >>> dadc_top_bench.sv
// Self-checking bench for the converter control block
module dadc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int W         = dadc_pkg::DATA_BITS;
   localparam int CYC_LIMIT = 20000;  // Whole run needs under 5000 cycles

   logic          mclk = 1'b0;      // System clock
   logic          srst = 1'b1;      // Reset
   logic [W-1:0]  ch0  = '0;        // Channel 0 input
   logic [W-1:0]  ch1  = '0;        // Channel 1 input
   logic          sck_pin, convert_strobe, sdo_out, sdo_oe;
   logic          convert_strobe_busy, acquiring, nap_active, sleep_active, reference_on;
   logic          frame_done, oe_gap;
   logic [31:0]   frame_word;
   logic [31:0]   seed  = 32'hF5BD6AE4;  // Random state
   logic [31:0]   cap_q = '0;            // Frame packed at the last strobe
   logic [31:0]   exp_q[$];              // Expected frames, oldest first
   int            err_count = 0, samples_checked = 0, cyc = 0;

   always #20 mclk = ~mclk;

   dadc_top dut_u (.mclk(mclk), .srst(srst), .sck_pin(sck_pin), .convert_strobe(convert_strobe),
      .channel_zero_positive(ch0), .channel_one_positive(ch1), .serial_result_out(sdo_out),
      .serial_result_oe(sdo_oe), .convert_strobe_busy(convert_strobe_busy), .acquiring(acquiring),
      .nap_active(nap_active), .sleep_active(sleep_active), .reference_on(reference_on));
   dadc_host_model host_u (.mclk(mclk), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sck_pin(sck_pin),
      .convert_strobe(convert_strobe), .frame_done(frame_done), .frame_word(frame_word),
      .oe_gap(oe_gap));

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   task automatic conclude();
      $display("checked %0d, errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic chk_frame(input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL frame expected %h seen %h", exp, got);
      end
   endtask

   task automatic chk_pwr(input logic n, input logic s, input logic r);
      chk_bit("nap_active", n, nap_active);
      chk_bit("sleep_active", s, sleep_active);
      chk_bit("reference_on", r, reference_on);
   endtask

   // Each strobe packs what it captures; the next frame must show it
   task automatic strobe(output logic [31:0] prev);
      prev  = cap_q;
      cap_q = {2'b00, ch0, 2'b00, ch1};
      host_u.strobe_pulse();
   endtask

   // Inputs are scrambled after capture so a leaky hold shows in the next frame
   task automatic frame(input logic ones);
      logic [31:0] prev;
      seed = xs(seed);
      ch0 <= ones ? '1 : seed[W-1:0];
      ch1 <= ones ? '1 : seed[W+15:16];
      @(posedge mclk);
      strobe(prev);
      exp_q.push_back(prev);
      ch0 <= ~ch0;
      ch1 <= ch0 ^ ch1;
      chk_bit("convert_strobe_busy", 1'b1, convert_strobe_busy);
      chk_bit("acquiring", 1'b0, acquiring);
      host_u.sck_pulses(32);
      chk_bit("oe", 1'b0, sdo_oe);
      chk_bit("acquiring", 1'b1, acquiring);
      chk_bit("convert_strobe_busy", 1'b0, convert_strobe_busy);
   endtask

   // --------------------------------------------------------------
   // Result watcher and hang guard
   // --------------------------------------------------------------
   always @(posedge mclk)
      if (frame_done === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk_bit("frame expected", 1'b1, 1'b0);
         else
            chk_frame(exp_q.pop_front(), frame_word);
         chk_bit("line released in frame", 1'b0, oe_gap);
      end

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == CYC_LIMIT)
      begin
         err_count++;
         conclude();
      end
   end

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial
   begin
      logic [31:0] p;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      chk_pwr(1'b0, 1'b0, 1'b1);
      chk_bit("acquiring", 1'b1, acquiring);
      chk_bit("oe", 1'b0, sdo_oe);
      for (int i = 0; i < 6; i++) frame(i == 3);
      repeat (2) strobe(p);
      chk_pwr(1'b1, 1'b0, 1'b1);
      host_u.sck_pulses(1);
      chk_pwr(1'b0, 1'b0, 1'b1);
      repeat (3) strobe(p);
      chk_pwr(1'b1, 1'b0, 1'b1);
      strobe(p);
      chk_pwr(1'b0, 1'b1, 1'b0);
      strobe(p);
      chk_pwr(1'b0, 1'b1, 1'b0);
      host_u.sck_pulses(1);
      chk_pwr(1'b0, 1'b0, 1'b0);
      repeat (2) strobe(p);
      chk_pwr(1'b1, 1'b0, 1'b1);
      host_u.sck_pulses(1);
      chk_pwr(1'b0, 1'b0, 1'b1);
      frame(1'b0);
      frame(1'b0);
      repeat (4) @(posedge mclk);
      chk_bit("queue empty", 1'b1, exp_q.size() == 0);
      conclude();
   end
endmodule
